// ### adc_seq_pkg.sv
// constants and types shared by the converter control block
// Behaviour
// - single conversion gives 12-bit unsigned, refreshed each time
// - justify bit picks right or left alignment of single results; sums stay right aligned
// - unused result bits always read zero
// - accumulated sum updates after final series conversion
// - accumulate 4, 8 or 16 samples by field
// - conversion spans at least 13 SAR clocks
// - conversion adds two system clock cycles
// - startup delay is (field plus one) times 200ns
// - burst off: power follows enable bit
// - burst on, enabled: converter stays powered
// - burst on, disabled: power up per start
// - tracking mode field selects post, pre, dual
// - post-track time 2..16 SAR clocks plus two
// - window compare on each result sets flag
// - limit ordering selects inside or outside window
// - window flag readable for polling
package adc_seq_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_TRACK = 8'hBA;
   localparam logic [7:0] IDX_CFG   = 8'hBC;
   localparam logic [7:0] IDX_RES_H = 8'hBD;
   localparam logic [7:0] IDX_RES_L = 8'hBE;
   localparam logic [7:0] IDX_GT_L  = 8'hC3;
   localparam logic [7:0] IDX_GT_H  = 8'hC4;
   localparam logic [7:0] IDX_LT_L  = 8'hC5;
   localparam logic [7:0] IDX_LT_H  = 8'hC6;
   localparam logic [7:0] IDX_CTRL  = 8'hE8;
   // reset values
   localparam logic [7:0]  TRACK_RST = 8'hFF;
   localparam logic [1:0]  RPT_RST   = 2'h0;
   localparam logic [15:0] GT_RST    = 16'hFFFF;
   localparam logic [15:0] LT_RST    = 16'h0000;
   // control register bit positions
   localparam int CTRL_EN_BIT    = 7;
   localparam int CTRL_BURST_BIT = 6;
   localparam int CTRL_DONE_BIT  = 5;
   localparam int CTRL_START_BIT = 4;
   localparam int CTRL_WIN_BIT   = 3;
   localparam int CTRL_LJ_BIT    = 2;
   // config and tracking field positions
   localparam int CFG_RPT_LSB = 1;
   localparam int TRK_PWR_LSB = 4;
   localparam int TRK_TM_LSB  = 2;
   localparam int TRK_TK_LSB  = 0;
   // timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int CLK_NS       = 10;
   localparam int SAR_MAX_HZ   = 3_600_000;
   localparam int SAR_DIV      = (CLK_HZ + SAR_MAX_HZ - 1) / SAR_MAX_HZ;
   localparam int SAR_HALF     = SAR_DIV / 2;
   localparam int PWR_UNIT_NS  = 200;
   localparam int PWR_UNIT_CYC = (PWR_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_SAR     = 13;
   localparam int EDGE_CYC     = 2;
   localparam int CONV_CYC     = CONV_SAR * SAR_DIV + EDGE_CYC;
   // tracking mode codes
   typedef enum logic [1:0] {
      TM_RSVD = 2'h0,
      TM_POST = 2'h1,
      TM_PRE  = 2'h2,
      TM_DUAL = 2'h3
   } track_mode_t;
endpackage

// ### adc_window_cmp.sv
// window comparator on a formatted 16-bit result
module adc_window_cmp (
   input  wire logic [15:0] value,
   input  wire logic [15:0] greater_limit,
   input  wire logic [15:0] less_limit,
   output logic             match
);
   // limit ordering alone picks inside or outside detection
   always_comb begin
      // inside window when less limit is higher
      if (less_limit > greater_limit) begin
         match = (value > greater_limit) && (value < less_limit);
      end else begin
         match = (value > greater_limit) || (value < less_limit);
      end
   end
endmodule

// ### adc_conv_sequencer.sv
// power, tracking and conversion timing toward the analog core
module adc_conv_sequencer (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        start,         // one-cycle start request
   input  wire logic        conv_enable,
   input  wire logic        burst_enable,
   input  wire logic [3:0]  pwr_code,
   input  wire logic [1:0]  track_mode,
   input  wire logic [1:0]  track_code,
   input  wire logic [11:0] core_data,     // from the analog core
   output logic             sar_clk,
   output logic             core_power,
   output logic             core_track,
   output logic             core_convert,
   output logic [11:0]      sample,
   output logic             sample_valid,
   output logic             busy
);
   // one-hot sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_PWRUP = 4'b0010,
      S_TRACK = 4'b0100,
      S_CONV  = 4'b1000
   } seq_state_t;

   typedef struct packed {
      seq_state_t  state;
      logic [9:0]  cnt;      // cycles left in current phase
      logic [4:0]  div;      // sar clock divider
      logic        sclk;
      logic [11:0] sync1;    // first stage, read only by sync2
      logic [11:0] sync2;
      logic [11:0] sample;
      logic        valid;
   } seq_regs_t;

   seq_regs_t r;
   seq_regs_t nxt;

   // post-track count load, its length in system cycles minus one
   function automatic logic [9:0] post_cycles(input logic [1:0] code);
      int n;
      n = (2 << code) * adc_seq_pkg::SAR_DIV + adc_seq_pkg::EDGE_CYC;
      return 10'(n - 1);
   endfunction

   // first phase after a start or power-up
   function automatic seq_state_t first_state(input logic [1:0] mode);
      // pre-tracking already tracked, convert at once
      if (mode == adc_seq_pkg::TM_PRE)
         return S_CONV;
      return S_TRACK;
   endfunction

   // matching count for that phase
   function automatic logic [9:0] first_cnt(input logic [1:0] mode,
                                            input logic [1:0] code);
      if (mode == adc_seq_pkg::TM_PRE)
         return 10'(adc_seq_pkg::CONV_CYC - 1);
      return post_cycles(code);
   endfunction

   // next-state logic
   always_comb begin
      nxt = r;
      nxt.valid = 1'b0;
      nxt.sync1 = core_data;
      nxt.sync2 = r.sync1;
      // free-running sar clock, kept under its maximum rate
      if (r.div == 5'(adc_seq_pkg::SAR_HALF - 1)) begin
         nxt.div = 5'h00;
         nxt.sclk = ~r.sclk;
      end else begin
         nxt.div = r.div + 5'h01;
      end
      if (r.cnt != 10'h000)
         nxt.cnt = r.cnt - 10'h001;
      unique case (r.state)
         S_IDLE: begin
            // converter fully off ignores starts
            if (start && (conv_enable || burst_enable)) begin
               if (burst_enable && !conv_enable) begin
                  nxt.state = S_PWRUP;
                  nxt.cnt = 10'((int'(pwr_code) + 1)
                                * adc_seq_pkg::PWR_UNIT_CYC - 1);
               end else begin
                  nxt.state = first_state(track_mode);
                  nxt.cnt = first_cnt(track_mode, track_code);
               end
            end
         end
         S_PWRUP: begin
            if (r.cnt == 10'h000) begin
               nxt.state = first_state(track_mode);
               nxt.cnt = first_cnt(track_mode, track_code);
            end
         end
         S_TRACK: begin
            // post-track sar periods plus two cycles
            if (r.cnt == 10'h000) begin
               nxt.state = S_CONV;
               nxt.cnt = 10'(adc_seq_pkg::CONV_CYC - 1);
            end
         end
         S_CONV: begin
            // thirteen sar clocks plus two cycles
            if (r.cnt == 10'h000) begin
               nxt.state = S_IDLE;
               nxt.sample = r.sync2;
               nxt.valid = 1'b1;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= '{state: S_IDLE, default: '0};
      end else begin
         r <= nxt;
      end
   end

   // power follows enable unless a burst is running
   assign core_power = burst_enable ? (conv_enable || r.state != S_IDLE)
                                    : conv_enable;
   // idle tracking only in pre and dual modes
   assign core_track = (r.state == S_TRACK) ||
                       (r.state == S_IDLE && core_power &&
                        track_mode[1]);
   assign core_convert = (r.state == S_CONV);
   assign sar_clk      = r.sclk;
   assign sample       = r.sample;
   assign sample_valid = r.valid;
   assign busy         = (r.state != S_IDLE);
endmodule

// ### adc_sequencer_window_detect.sv
// register file, result formatting, accumulation and window flag
module adc_sequencer_window_detect (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // avalon-mm slave, byte address
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // analog core side
   input  wire logic [11:0] core_data,
   output logic             sar_clk,
   output logic             core_power,
   output logic             core_track,
   output logic             core_convert,
   // status toward the system
   output logic             window_match_flag,
   output logic             conv_busy
);
   typedef struct packed {
      logic [7:0]  tracking_config_reg;
      logic        converter_enable;
      logic        burst_mode_enable;
      logic        left_justify_sel;
      logic        done_flag;        // series complete
      logic        win_flag;         // window match
      logic [1:0]  repeat_count_sel;
      logic [15:0] greater_limit;
      logic [15:0] less_limit;
      logic [15:0] result;           // shown as high and low bytes
      logic [15:0] acc;
      logic [3:0]  acc_cnt;          // samples taken in series
      logic        start;            // start pulse to sequencer
      logic        ack;              // bus answer phase
      logic [7:0]  rdata;
   } top_regs_t;

   top_regs_t r;
   top_regs_t nxt;

   logic [11:0] sample;
   logic        sample_valid;
   logic        seq_busy;
   logic [15:0] sum;
   logic [15:0] fmt_value;
   logic        last;
   logic        match;
   logic [7:0]  idx;
   logic        req;

   // samples per series for a repeat code
   function automatic logic [4:0] series_len(input logic [1:0] code);
      // codes 1..3 give 4, 8, 16
      if (code == 2'h0)
         return 5'h01;
      return 5'(5'h02 << code);
   endfunction

   // formatted result for the result registers
   function automatic logic [15:0] format_result(input logic [1:0] code,
                                                 input logic lj,
                                                 input logic [15:0] s);
      if (code != 2'h0)
         return s;
      // left alignment puts data in upper twelve bits
      if (lj)
         return {s[11:0], 4'h0};
      // right aligned with upper nibble zero
      return {4'h0, s[11:0]};
   endfunction

   assign idx  = avs_address[9:2];
   assign req  = avs_read || avs_write;
   // sum restarts from zero on the first sample
   assign sum  = ((r.acc_cnt == 4'h0) ? 16'h0000 : r.acc)
                 + {4'h0, sample};
   assign last = ({1'b0, r.acc_cnt} ==
                  series_len(r.repeat_count_sel) - 5'h01);
   assign fmt_value = format_result(r.repeat_count_sel,
                                    r.left_justify_sel, sum);

   // window compared against the value about to be shown
   adc_window_cmp u_window (
      .value         (fmt_value),
      .greater_limit (r.greater_limit),
      .less_limit    (r.less_limit),
      .match         (match)
   );

   // power and timing toward the core
   adc_conv_sequencer u_seq (
      .clk_sys      (clk_sys),
      .rstn         (rstn),
      .start        (r.start),
      .conv_enable  (r.converter_enable),
      .burst_enable (r.burst_mode_enable),
      .pwr_code     (r.tracking_config_reg[adc_seq_pkg::TRK_PWR_LSB +: 4]),
      .track_mode   (r.tracking_config_reg[adc_seq_pkg::TRK_TM_LSB +: 2]),
      .track_code   (r.tracking_config_reg[adc_seq_pkg::TRK_TK_LSB +: 2]),
      .core_data    (core_data),
      .sar_clk      (sar_clk),
      .core_power   (core_power),
      .core_track   (core_track),
      .core_convert (core_convert),
      .sample       (sample),
      .sample_valid (sample_valid),
      .busy         (seq_busy)
   );

   // bus, register and accumulation next state
   always_comb begin
      nxt = r;
      nxt.start = 1'b0;
      // one wait state: capture in first cycle, answer in second
      nxt.ack = req && !r.ack;
      if (req && !r.ack) begin
         unique case (idx)
            adc_seq_pkg::IDX_TRACK: nxt.rdata = r.tracking_config_reg;
            adc_seq_pkg::IDX_CTRL: begin
               nxt.rdata = 8'h00;
               nxt.rdata[adc_seq_pkg::CTRL_EN_BIT] = r.converter_enable;
               nxt.rdata[adc_seq_pkg::CTRL_BURST_BIT] = r.burst_mode_enable;
               nxt.rdata[adc_seq_pkg::CTRL_DONE_BIT] = r.done_flag;
               nxt.rdata[adc_seq_pkg::CTRL_START_BIT] = seq_busy;
               nxt.rdata[adc_seq_pkg::CTRL_WIN_BIT] = r.win_flag;
               nxt.rdata[adc_seq_pkg::CTRL_LJ_BIT] = r.left_justify_sel;
            end
            adc_seq_pkg::IDX_CFG:
               nxt.rdata = {5'h00, r.repeat_count_sel, 1'b0};
            // unused bits are zero in the stored result
            adc_seq_pkg::IDX_RES_H: nxt.rdata = r.result[15:8];
            adc_seq_pkg::IDX_RES_L: nxt.rdata = r.result[7:0];
            adc_seq_pkg::IDX_GT_H:  nxt.rdata = r.greater_limit[15:8];
            adc_seq_pkg::IDX_GT_L:  nxt.rdata = r.greater_limit[7:0];
            adc_seq_pkg::IDX_LT_H:  nxt.rdata = r.less_limit[15:8];
            adc_seq_pkg::IDX_LT_L:  nxt.rdata = r.less_limit[7:0];
            // unmapped reads answer zero
            default: nxt.rdata = 8'h00;
         endcase
      end
      // writes land on the answering edge
      if (avs_write && r.ack) begin
         unique case (idx)
            adc_seq_pkg::IDX_TRACK:
               nxt.tracking_config_reg = avs_writedata[7:0];
            adc_seq_pkg::IDX_CTRL: begin
               nxt.converter_enable =
                  avs_writedata[adc_seq_pkg::CTRL_EN_BIT];
               nxt.burst_mode_enable =
                  avs_writedata[adc_seq_pkg::CTRL_BURST_BIT];
               nxt.done_flag = avs_writedata[adc_seq_pkg::CTRL_DONE_BIT];
               nxt.win_flag = avs_writedata[adc_seq_pkg::CTRL_WIN_BIT];
               nxt.left_justify_sel =
                  avs_writedata[adc_seq_pkg::CTRL_LJ_BIT];
               nxt.start = avs_writedata[adc_seq_pkg::CTRL_START_BIT];
            end
            adc_seq_pkg::IDX_CFG: begin
               nxt.repeat_count_sel =
                  avs_writedata[adc_seq_pkg::CFG_RPT_LSB +: 2];
               // new repeat setting opens a fresh series
               nxt.acc_cnt = 4'h0;
            end
            adc_seq_pkg::IDX_GT_H:
               nxt.greater_limit[15:8] = avs_writedata[7:0];
            adc_seq_pkg::IDX_GT_L:
               nxt.greater_limit[7:0] = avs_writedata[7:0];
            adc_seq_pkg::IDX_LT_H:
               nxt.less_limit[15:8] = avs_writedata[7:0];
            adc_seq_pkg::IDX_LT_L:
               nxt.less_limit[7:0] = avs_writedata[7:0];
            // unmapped writes are dropped
            default: ;
         endcase
      end
      // sample arrival, after the bus so a hardware set beats a clear
      if (sample_valid) begin
         if (last) begin
            // results change only when the series ends
            nxt.result = fmt_value;
            nxt.acc_cnt = 4'h0;
            nxt.done_flag = 1'b1;
            // compare each new result, set on match
            if (match)
               nxt.win_flag = 1'b1;
         end else begin
            // sixteen 12-bit samples fit in 16 bits
            nxt.acc = sum;
            nxt.acc_cnt = r.acc_cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= '{tracking_config_reg: adc_seq_pkg::TRACK_RST,
                repeat_count_sel: adc_seq_pkg::RPT_RST,
                greater_limit: adc_seq_pkg::GT_RST,
                less_limit: adc_seq_pkg::LT_RST,
                default: '0};
      end else begin
         r <= nxt;
      end
   end

   // bus answer stands in the cycle after capture
   assign avs_waitrequest   = req && !r.ack;
   assign avs_readdata      = {24'h000000, r.rdata};
   assign window_match_flag = r.win_flag;
   assign conv_busy         = seq_busy;
endmodule

// ### adc_core_model.sv
// behavioural analog core: hands back a set level per conversion
module adc_core_model (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        core_convert,
   input  wire logic [11:0] level,     // value to be converted
   output logic      [11:0] core_data
);
   logic [2:0] hold_r;  // short hold past convert for the input flops
   // keep data valid a few cycles after the convert phase
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) hold_r <= 3'h0;
      else if (core_convert) hold_r <= 3'h7;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
   end
   // outside a conversion and its short hold the lines carry junk, never the last value
   assign core_data = (core_convert || hold_r != 3'h0) ? level : ~level;
endmodule

// ### adc_sequencer_window_detect_chk.sv
// port-level assertions for the converter control block
module adc_sequencer_window_detect_chk (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        sar_clk,
   input wire logic        core_power,
   input wire logic        core_track,
   input wire logic        core_convert,
   input wire logic        conv_busy
);
   logic [7:0] ctrl_r;     // shadow of control register
   logic [7:0] trk_r;      // shadow of tracking register
   logic [9:0] cnv_r;      // cycles with convert high
   logic [9:0] tlen_r;     // cycles with track high
   logic       wr_ok;      // write completes this edge
   logic       nap;        // burst on, enable off
   logic       sclk_q;     // sar clock one edge ago
   logic [4:0] run_r;      // edges in current sar half period
   assign wr_ok = avs_write && !avs_waitrequest;
   assign nap = ctrl_r[6] && !ctrl_r[7];
   // shadows follow completed writes; counters time the phases
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= 8'h00;
         trk_r <= 8'hFF;
         cnv_r <= 10'h000;
         tlen_r <= 10'h000;
         sclk_q <= 1'b0;
         run_r <= 5'h00;
      end else begin
         // half period restarts at each sar clock change
         sclk_q <= sar_clk;
         run_r <= (sar_clk != sclk_q) ? 5'h01 : run_r + 5'h01;
         if (wr_ok && avs_address[9:2] == adc_seq_pkg::IDX_CTRL)
            ctrl_r <= avs_writedata[7:0];
         if (wr_ok && avs_address[9:2] == adc_seq_pkg::IDX_TRACK)
            trk_r <= avs_writedata[7:0];
         cnv_r <= core_convert ? cnv_r + 10'h001 : 10'h000;
         tlen_r <= core_track ? tlen_r + 10'h001 : 10'h000;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_conv_len: assert property ($fell(core_convert) |->
      cnv_r == adc_seq_pkg::CONV_CYC) else $error("convert length off");
   a_post_len: assert property ($fell(core_track) && core_convert
      && !trk_r[3] |-> tlen_r == (2 << trk_r[1:0]) * adc_seq_pkg::SAR_DIV
      + adc_seq_pkg::EDGE_CYC) else $error("post-track length off");
   a_power_follow: assert property (!ctrl_r[6] |->
      core_power == ctrl_r[7]) else $error("power not following enable");
   a_burst_awake: assert property (ctrl_r[6] && ctrl_r[7] |->
      core_power) else $error("powered down while enabled");
   a_burst_rest: assert property (nap && !conv_busy |->
      !core_power) else $error("idle burst core not resting");
   a_busy_power: assert property (conv_busy |-> core_power)
      else $error("busy while unpowered");
   a_pre_direct: assert property ($rose(conv_busy) && !nap
      && trk_r[3:2] == 2'h2 |-> core_convert) else $error("pre not direct");
   a_post_first: assert property ($rose(conv_busy) && !nap
      && !trk_r[3] |-> core_track && !core_convert)
      else $error("post mode did not track first");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait state not single");
   a_data_upper: assert property (avs_read && !avs_waitrequest |->
      avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
   a_sar_half: assert property ($changed(sar_clk) |->
      run_r == 5'(adc_seq_pkg::SAR_HALF)) else $error("sar half period off");
endmodule
bind adc_sequencer_window_detect adc_sequencer_window_detect_chk u_chk (
   .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .sar_clk, .core_power, .core_track,
   .core_convert, .conv_busy);

// ### adc_sequencer_window_detect_bench.sv
// self-checking bench for the converter control block
module adc_sequencer_window_detect_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic [9:0]  avs_address = 10'h000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [11:0] core_data;
   logic [11:0] level = 12'h000;   // level the core model converts
   logic        sar_clk, core_power, core_track, core_convert;
   logic        window_match_flag, conv_busy;
   int          fails = 0;
   int          comparisons = 0;
   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;
   adc_sequencer_window_detect dut (.clk_sys, .rstn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .core_data, .sar_clk, .core_power, .core_track,
      .core_convert, .window_match_flag, .conv_busy);
   adc_core_model core (.clk_sys, .rstn, .core_convert, .level,
      .core_data);
   // verdict and end of run
   task stop_test;
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one counted compare
   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // avalon access, held until waitrequest is seen low
   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
            output logic [7:0] q);
      int n;
      @(posedge clk_sys);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h0, d};
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n == 20) fails++;
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task rd(input logic [7:0] idx, output logic [15:0] v);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      v = {8'h00, q};
   endtask
   // both result bytes, read while idle
   task res(output logic [15:0] v);
      logic [15:0] h, l;
      rd(adc_seq_pkg::IDX_RES_H, h);
      rd(adc_seq_pkg::IDX_RES_L, l);
      v = {h[7:0], l[7:0]};
   endtask
   // one start, bounded wait for the sequencer to finish
   task convert(input logic [7:0] ctl, input logic [11:0] v);
      int n;
      level <= v;
      wr(adc_seq_pkg::IDX_CTRL, ctl | 8'h10);
      for (n = 0; conv_busy !== 1'b1 && n < 10; n++) @(posedge clk_sys);
      if (n == 10) fails++;
      for (n = 0; conv_busy !== 1'b0 && n < 3000; n++) @(posedge clk_sys);
      if (n == 3000) fails++;
      repeat (3) @(posedge clk_sys);
   endtask
   // reset values, unmapped index last
   task t_reset;
      logic [7:0] ix [10];
      logic [7:0] ex [10];
      logic [15:0] v;
      ix = '{adc_seq_pkg::IDX_TRACK, adc_seq_pkg::IDX_CTRL,
             adc_seq_pkg::IDX_CFG, adc_seq_pkg::IDX_RES_H,
             adc_seq_pkg::IDX_RES_L, adc_seq_pkg::IDX_GT_L,
             adc_seq_pkg::IDX_GT_H, adc_seq_pkg::IDX_LT_L,
             adc_seq_pkg::IDX_LT_H, 8'h10};
      ex = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
             8'h00, 8'h00};
      for (int i = 0; i < 10; i++) begin
         rd(ix[i], v);
         check(v, {8'h00, ex[i]});
      end
   endtask
   // single results in both alignments; reset limits never match
   task t_single;
      logic [11:0] vs [3];
      logic [15:0] v;
      vs = '{12'hFFF, 12'h800, 12'h7FF};
      wr(adc_seq_pkg::IDX_TRACK, 8'h04);
      for (int j = 0; j < 2; j++)
         for (int k = 0; k < 3; k++) begin
            convert(j[0] ? 8'h84 : 8'h80, vs[k]);
            res(v);
            check(v, j[0] ? {vs[k], 4'h0} : {4'h0, vs[k]});
            check({15'h0, window_match_flag}, 16'h0000);
         end
   endtask
   // sums of 4, 8, 16; held until the last of a series
   task t_accum;
      logic [15:0] v, prev;
      res(prev);
      for (int c = 1; c < 4; c++) begin
         wr(adc_seq_pkg::IDX_CFG, 8'(c << 1));
         for (int i = 0; i < (2 << c); i++) begin
            convert(8'h80, 12'hFFF);
            if (i == (2 << c) - 2) begin
               res(v);
               check(v, prev);
            end
         end
         res(v);
         prev = 16'(4095 * (2 << c));
         check(v, prev);
      end
      wr(adc_seq_pkg::IDX_CFG, 8'h02);
      for (int i = 0; i < 4; i++) convert(8'h80, 12'h001);
      res(v);
      check(v, 16'h0004);
      wr(adc_seq_pkg::IDX_CFG, 8'h00);
   endtask
   // every tracking mode, post-track codes spread over the modes
   task t_modes;
      logic [15:0] v;
      for (int m = 0; m < 4; m++) begin
         wr(adc_seq_pkg::IDX_TRACK, 8'(m * 4 + (3 - m)));
         convert(8'h80, 12'h5A0 + 12'(m));
         res(v);
         check(v, 16'h05A0 + 16'(m));
      end
      wr(adc_seq_pkg::IDX_TRACK, 8'h04);
   endtask
   // inside and outside windows, boundary values tried for the inside window only
   task t_window;
      logic [15:0] gt [6];
      logic [15:0] lt [6];
      logic [11:0] vs [6];
      logic        ex [6];
      logic [15:0] r;
      gt = '{16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200};
      lt = '{16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100};
      vs = '{12'h180, 12'h200, 12'h100, 12'h201, 12'h0FF, 12'h180};
      ex = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         wr(adc_seq_pkg::IDX_GT_H, gt[i][15:8]);
         wr(adc_seq_pkg::IDX_GT_L, gt[i][7:0]);
         wr(adc_seq_pkg::IDX_LT_H, lt[i][15:8]);
         wr(adc_seq_pkg::IDX_LT_L, lt[i][7:0]);
         convert(8'h80, vs[i]);
         check({15'h0, window_match_flag}, {15'h0, ex[i]});
         rd(adc_seq_pkg::IDX_CTRL, r);
         check({15'h0, r[3]}, {15'h0, ex[i]});
      end
   endtask
   // burst power-up delay, rest and stay-awake
   task t_burst;
      int cnt;
      logic [15:0] v;
      wr(adc_seq_pkg::IDX_TRACK, 8'h34);
      wr(adc_seq_pkg::IDX_CTRL, 8'h40);
      @(posedge clk_sys);
      check({15'h0, core_power}, 16'h0000);
      level <= 12'h3C3;
      wr(adc_seq_pkg::IDX_CTRL, 8'h50);
      cnt = 0;
      repeat (1200) begin
         @(posedge clk_sys);
         if (core_power === 1'b1 && core_track === 1'b0
             && core_convert === 1'b0) cnt++;
      end
      check(16'(cnt), 16'(4 * adc_seq_pkg::PWR_UNIT_CYC));
      check({15'h0, core_power}, 16'h0000);
      res(v);
      check(v, 16'h03C3);
      wr(adc_seq_pkg::IDX_CTRL, 8'hC0);
      @(posedge clk_sys);
      check({15'h0, core_power}, 16'h0001);
      wr(adc_seq_pkg::IDX_CTRL, 8'h00);
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_single;
      t_accum;
      t_modes;
      t_window;
      t_burst;
      stop_test;
   end
   // watchdog, far beyond the expected run
   initial begin
      #500_000;
      fails++;
      stop_test;
   end
endmodule
